// ### dv/cfdmc_can_side.sv
`timescale 1ns/1ps
`default_nettype none
module cfdmc_can_side (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic abort_all_pending,
	input wire logic slow,
	input wire logic traffic,
	output logic     tx_active,
	output logic     rx_active,
	output logic     abort_done
);
	logic [4:0] wait_q;
	// slow selects reception instead of transmission; the testbench holds slow high while traffic is on, so only rx_active gets used
	assign tx_active = traffic & ~slow;
	assign rx_active = traffic & slow;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 5'h00;
			abort_done <= 1'h0;
		end else begin
			abort_done <= 1'h0;
			if (!abort_all_pending || abort_done)
				wait_q <= 5'h00;
			else if (wait_q == (slow ? 5'h10 : 5'h01))
				abort_done <= 1'h1;
			else
				wait_q <= wait_q + 5'h01;
		end
	end
endmodule
`default_nettype wire

// ### dv/cfdmc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cfdmc_ctrl_chk (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       system_error,
	input wire logic       abort_done,
	input wire logic       msg_esi,
	input wire logic       error_passive,
	input wire logic       msg_brs,
	input wire logic       wake_raw,
	input wire logic       wake_filtered,
	input wire logic       proto_exception,
	input wire logic [2:0] mode_status,
	input wire logic       abort_all_pending,
	input wire logic       transmit_queue_enable,
	input wire logic       transmit_queue_reserve,
	input wire logic       system_error_target,
	input wire logic       esi_tx,
	input wire logic       brs_tx,
	input wire logic       wake_detect,
	input wire logic       form_error,
	input wire logic       bus_integrate
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("wait state count wrong");
	chk_serr_mode: assert property (system_error |=>
		mode_status == ($past(system_error_target) ? 3'h3 : 3'h7))
		else $error("system error mode wrong");
	chk_abort_clear: assert property (abort_done && abort_all_pending && !avs_write
		|=> !abort_all_pending) else $error("abort bit not cleared");
	chk_esi_map: assert property (!msg_esi |=> esi_tx == $past(error_passive))
		else $error("esi level wrong");
	chk_brs_off: assert property (!msg_brs |=> !brs_tx)
		else $error("rate switch without request");
	chk_wake_mux: assert property (wake_raw == wake_filtered
		|=> wake_detect == $past(wake_raw)) else $error("wake detect wrong");
	chk_pxe_route: assert property (proto_exception |=> form_error != bus_integrate)
		else $error("exception not routed");
	chk_pxe_quiet: assert property (!proto_exception |=> !form_error && !bus_integrate)
		else $error("exception result without cause");
	chk_queue_reserve: assert property (transmit_queue_enable == transmit_queue_reserve)
		else $error("queue reserve mismatch");
	cover property (system_error);
	cover property (abort_done && abort_all_pending);
	cover property (proto_exception);
endmodule
bind cfdmc_ctrl cfdmc_ctrl_chk cfdmc_ctrl_chk_i (.*);
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk, rst, avs_read, avs_write, avs_waitrequest, irq;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdat;
	logic        tx_active, rx_active, abort_done, system_error, msg_esi, error_passive;
	logic        msg_brs, wake_raw, wake_filtered, proto_exception, arb_bit_tick;
	logic        tx_frame_done, slow, traffic, abort_all_pending, transmit_queue_enable;
	logic        store_sent_events, system_error_target, esi_tx, brs_tx, wake_detect;
	logic        crc_stuff_count_en, tx_gap_clear, sent_event_reserve, retry_limit_active;
	logic        form_error, bus_integrate, crc_init_nonzero;
	logic [4:0]  data_byte_filter_count;
	logic [1:0]  retry_attempt_setting, retry_attempt_used, wake_filter_time;
	logic [2:0]  mode_status;
	logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h5, 4'hb, 4'hc, 4'hf};
	logic [31:0] gaps [6] = '{32'h0, 32'h2, 32'h20, 32'h800, 32'h1000, 32'h1000};
	int          err_count, checked, cyc, n, i;
	cfdmc_ctrl cfdmc_ctrl_i (.*, .avs_byteenable(4'hf), .transmit_queue_reserve());
	cfdmc_can_side cfdmc_can_side_i (.*);
	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end
	task wrap_up;
		if (err_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			wrap_up();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// waitrequest and read data are taken at the edge, before that edge updates them
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
		rdat = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		acc(1'h0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task pulse_serr;
		@(posedge core_clk);
		system_error <= 1'h1;
		@(posedge core_clk);
		system_error <= 1'h0;
		repeat (2) @(posedge core_clk);
	endtask
	initial begin
		{rst, avs_read, avs_write, avs_address, avs_writedata} = {1'h1, 42'h0};
		{system_error, msg_esi, error_passive, msg_brs, wake_raw, wake_filtered} = 6'h0;
		{proto_exception, arb_bit_tick, tx_frame_done, slow, traffic} = 5'h0;
		retry_attempt_setting = 2'h0;
		{err_count, checked, cyc} = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'h0;
		rd(8'h00, 32'h0498_0760, "ctrl_reset");
		rd(8'h08, 32'h0, "mask_reset");
		rd(8'h0c, 32'h0, "unmapped");
		acc(1'h1, 8'h0c, 32'hffff_ffff);
		acc(1'h1, 8'h00, 32'h04e7_f28a);
		rd(8'h00, 32'h0487_120a, "ctrl_cfg");
		chk("queue_en", 32'h0, transmit_queue_enable);
		chk("event_store", 32'h0, store_sent_events);
		chk("event_reserve", 32'h0, sent_event_reserve);
		chk("crc", 32'h0, crc_stuff_count_en);
		chk("crc_init", 32'h0, crc_init_nonzero);
		chk("wake_time", 32'h1, wake_filter_time);
		chk("retry_on", 32'h1, retry_limit_active);
		chk("serr_target", 32'h1, system_error_target);
		chk("byte_count", 32'ha, data_byte_filter_count);
		msg_brs <= 1'h1;
		msg_esi <= 1'h1;
		wake_raw <= 1'h1;
		retry_attempt_setting <= 2'h2;
		proto_exception <= 1'h1;
		@(posedge core_clk);
		proto_exception <= 1'h0;
		@(negedge core_clk);
		chk("integrate", 32'h1, bus_integrate);
		chk("form_err", 32'h0, form_error);
		repeat (2) @(posedge core_clk);
		chk("brs", 32'h0, brs_tx);
		chk("esi", 32'h1, esi_tx);
		chk("retry", 32'h2, retry_attempt_used);
		chk("wake", 32'h1, wake_detect);
		for (i = 0; i < 6; i++) begin
			acc(1'h1, 8'h00, {codes[i], 28'h487_1200});
			@(posedge core_clk);
			tx_frame_done <= 1'h1;
			@(posedge core_clk);
			tx_frame_done <= 1'h0;
			arb_bit_tick <= 1'h1;
			n = 0;
			@(negedge core_clk);
			while (tx_gap_clear !== 1'h1 && n < 5000) begin
				n++;
				@(negedge core_clk);
			end
			@(posedge core_clk);
			arb_bit_tick <= 1'h0;
			chk("gap", gaps[i], n);
		end
		slow <= 1'h1;
		acc(1'h1, 8'h00, 32'h0c87_1200);
		rd(8'h00, 32'h0c87_1200, "abort_set");
		for (n = 0; n < 100 && abort_all_pending !== 1'h0; n++) @(negedge core_clk);
		chk("abort_clr", 32'h0, abort_all_pending);
		rd(8'h04, 32'ha, "int_stat");
		chk("irq_masked", 32'h0, irq);
		acc(1'h1, 8'h08, 32'h2);
		@(negedge core_clk);
		chk("irq_on", 32'h1, irq);
		acc(1'h1, 8'h04, 32'h2);
		@(negedge core_clk);
		chk("irq_off", 32'h0, irq);
		rd(8'h04, 32'h8, "int_w1c");
		traffic <= 1'h1;
		repeat (2) @(posedge core_clk);
		rd(8'h00, 32'h0487_1a00, "busy");
		acc(1'h1, 8'h00, 32'h0007_1200);
		repeat (4) @(posedge core_clk);
		chk("mode_wait", 32'h4, mode_status);
		traffic <= 1'h0;
		repeat (3) @(posedge core_clk);
		chk("mode_free", 32'h0, mode_status);
		for (i = 0; i < 8; i++) begin
			acc(1'h1, 8'h00, {5'h0, i[2:0], 24'h07_1200});
			repeat (2) @(posedge core_clk);
			chk("mode", i, mode_status);
		end
		acc(1'h1, 8'h00, 32'h0718_1200);
		rd(8'h00, 32'h07e7_1200, "locked");
		acc(1'h1, 8'h00, 32'h0007_1200);
		pulse_serr();
		chk("serr_lom", 32'h3, mode_status);
		acc(1'h1, 8'h00, 32'h0403_1200);
		n = 0;
		do begin
			acc(1'h0, 8'h00, 32'h0);
			n++;
		end while (rdat[23:21] !== 3'h4 && n < 20);
		chk("cfg_reached", 32'h4, rdat[23:21]);
		acc(1'h1, 8'h00, 32'h0403_1200);
		pulse_serr();
		chk("serr_rom", 32'h7, mode_status);
		rd(8'h04, 32'hd, "int_all");
		wrap_up();
	end
endmodule
`default_nettype wire

// ### logic/cfdmc_ctrl.v
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cfdmc_regs.vh"

module cfdmc_ctrl #(
	parameter ADDR_W = 8
) (
	input  wire              core_clk,
	input  wire              rst,
	input  wire [ADDR_W-1:0] avs_address,
	input  wire              avs_read,
	input  wire              avs_write,
	input  wire [31:0]       avs_writedata,
	input  wire [3:0]        avs_byteenable,
	output reg  [31:0]       avs_readdata,
	output wire              avs_waitrequest,
	output wire              irq,
	input  wire              tx_active,
	input  wire              rx_active,
	input  wire              system_error,
	input  wire              abort_done,
	input  wire              msg_esi,
	input  wire              error_passive,
	input  wire              msg_brs,
	input  wire [1:0]        retry_attempt_setting,
	input  wire              wake_raw,
	input  wire              wake_filtered,
	input  wire              proto_exception,
	input  wire              arb_bit_tick,
	input  wire              tx_frame_done,
	output wire [2:0]        mode_status,
	output wire              abort_all_pending,
	output wire              transmit_queue_enable,
	output wire              transmit_queue_reserve,
	output wire              store_sent_events,
	output wire              sent_event_reserve,
	output wire              system_error_target,
	output reg               esi_tx,
	output reg               retry_limit_active,
	output reg  [1:0]        retry_attempt_used,
	output reg               brs_tx,
	output wire [1:0]        wake_filter_time,
	output reg               wake_detect,
	output reg               form_error,
	output reg               bus_integrate,
	output wire              crc_stuff_count_en,
	output wire              crc_init_nonzero,
	output wire [4:0]        data_byte_filter_count,
	output wire              tx_gap_clear
);

	// bus access sequencing, one-hot
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK  = 2'b10;

	reg  [1:0]  bus_st_q;
	reg  [3:0]  gap_q;
	reg         abort_q;
	reg  [2:0]  req_q;
	reg  [2:0]  cur_q;
	reg         queue_en_q;
	reg         evt_store_q;
	reg         serr_q;
	reg         gw_q;
	reg         retry_q;
	reg         rate_dis_q;
	reg         busy_q;
	reg  [1:0]  wake_time_q;
	reg         waken_q;
	reg         pxd_q;
	reg         crc_q;
	reg  [4:0]  dbc_q;
	reg  [`CFDMC_IRQ_W-1:0] int_stat_q;
	reg  [`CFDMC_IRQ_W-1:0] int_mask_q;

	wire        access;
	wire        commit;
	wire        sel_ctrl;
	wire        sel_stat;
	wire        sel_mask;
	wire        wr_ctrl;
	wire        in_config;
	wire [31:0] be_mask;
	wire [31:0] ctrl_view;
	wire [31:0] ctrl_new;
	wire        mode_switch;
	wire [`CFDMC_IRQ_W-1:0] int_events;
	wire [`CFDMC_IRQ_W-1:0] int_clear;
	reg  [2:0]  cur_d;
	reg  [2:0]  req_d;
	reg  [31:0] rd_mux;

	assign access   = avs_read | avs_write;
	// one wait state: the request is taken at the edge after waitrequest drops
	assign avs_waitrequest = access & ~bus_st_q[1];
	assign commit   = access & bus_st_q[1];

	assign sel_ctrl = (avs_address == `CFDMC_OFS_CONTROL);
	assign sel_stat = (avs_address == `CFDMC_OFS_INT_STAT);
	assign sel_mask = (avs_address == `CFDMC_OFS_INT_MASK);
	assign wr_ctrl  = commit & avs_write & sel_ctrl;

	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// unused positions are constant zero, so reads of them show zero
	assign ctrl_view = {gap_q, abort_q, req_q, cur_q, queue_en_q, evt_store_q, serr_q,
	                    gw_q, retry_q, 3'h0, rate_dis_q, busy_q, wake_time_q,
	                    waken_q, 1'b0, pxd_q, crc_q, dbc_q};

	// lanes not enabled keep their present contents
	assign ctrl_new = (avs_writedata & be_mask) | (ctrl_view & ~be_mask);

	// protected bits follow the mode reached, not the one requested
	assign in_config = (cur_q == `CFDMC_MODE_CONFIG);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_st_q <= ST_IDLE;
		end else begin
			case (bus_st_q)
			ST_IDLE: begin
				if (access) begin
					bus_st_q <= ST_ACK;
				end
			end
			ST_ACK: begin
				bus_st_q <= ST_IDLE;
			end
			default: begin
				bus_st_q <= ST_IDLE;
			end
			endcase
		end
	end

	always @* begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_mux = ctrl_view;
		end else if (sel_stat) begin
			rd_mux = {{(32-`CFDMC_IRQ_W){1'b0}}, int_stat_q};
		end else if (sel_mask) begin
			rd_mux = {{(32-`CFDMC_IRQ_W){1'b0}}, int_mask_q};
		end
	end

	// read data is loaded as the wait state ends and stands through the commit edge
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && bus_st_q[0]) begin
			avs_readdata <= rd_mux;
		end
	end

	// a requested mode change waits until the engine is idle; a system error forces its mode at once
	assign mode_switch = (req_q != cur_q) && !busy_q;

	always @* begin
		req_d = req_q;
		if (wr_ctrl) begin
			req_d = ctrl_new[`CFDMC_REQ_LSB+2:`CFDMC_REQ_LSB];
		end
		if (system_error) begin
			req_d = serr_q ? `CFDMC_MODE_LISTEN : `CFDMC_MODE_RESTRICT;
		end
	end

	always @* begin
		cur_d = cur_q;
		if (system_error) begin
			cur_d = serr_q ? `CFDMC_MODE_LISTEN : `CFDMC_MODE_RESTRICT;
		end else if (mode_switch) begin
			cur_d = req_q;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			req_q  <= `CFDMC_MODE_CONFIG;
			cur_q  <= `CFDMC_MODE_CONFIG;
			busy_q <= 1'b0;
		end else begin
			req_q  <= req_d;
			cur_q  <= cur_d;
			busy_q <= tx_active | rx_active;
		end
	end

	// hardware-owned clear; a software zero does not cancel a running abort
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			abort_q <= 1'b0;
		end else if (wr_ctrl && ctrl_new[`CFDMC_ABORT_BIT]) begin
			abort_q <= 1'b1;
		end else if (abort_done) begin
			abort_q <= 1'b0;
		end
	end

	// freely writable fields
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gap_q    <= `CFDMC_RST_GAP;
			rate_dis_q  <= 1'b0;
			wake_time_q <= `CFDMC_RST_WAKE_TIME;
			crc_q    <= `CFDMC_RST_CRC;
			dbc_q    <= `CFDMC_RST_DBC;
		end else if (wr_ctrl) begin
			gap_q    <= ctrl_new[`CFDMC_GAP_LSB+3:`CFDMC_GAP_LSB];
			rate_dis_q  <= ctrl_new[`CFDMC_RATE_DIS_BIT];
			wake_time_q <= ctrl_new[`CFDMC_WAKE_TIME_LSB+1:`CFDMC_WAKE_TIME_LSB];
			crc_q    <= ctrl_new[`CFDMC_CRC_BIT];
			dbc_q    <= ctrl_new[`CFDMC_DBC_LSB+4:`CFDMC_DBC_LSB];
		end
	end

	// option bits that reshape memory or protocol; frozen outside configuration
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			queue_en_q  <= `CFDMC_RST_QUEUE_EN;
			evt_store_q <= `CFDMC_RST_EVT_STORE;
			serr_q  <= 1'b0;
			gw_q    <= 1'b0;
			retry_q <= 1'b0;
			waken_q <= `CFDMC_RST_WAKEN;
			pxd_q   <= `CFDMC_RST_PXD;
		end else if (wr_ctrl && in_config) begin
			queue_en_q  <= ctrl_new[`CFDMC_QUEUE_EN_BIT];
			evt_store_q <= ctrl_new[`CFDMC_EVT_STORE_BIT];
			serr_q  <= ctrl_new[`CFDMC_SERR_BIT];
			gw_q    <= ctrl_new[`CFDMC_GW_BIT];
			retry_q <= ctrl_new[`CFDMC_RETRY_BIT];
			waken_q <= ctrl_new[`CFDMC_WAKEN_BIT];
			pxd_q   <= ctrl_new[`CFDMC_PXD_BIT];
		end
	end

	// a forced mode change reports as system error, not as mode change
	assign int_events[`CFDMC_IRQ_MODE]  = mode_switch & ~system_error;
	assign int_events[`CFDMC_IRQ_ABORT] = abort_q & abort_done;
	assign int_events[`CFDMC_IRQ_SERR]  = system_error;
	assign int_events[`CFDMC_IRQ_PXE]   = proto_exception;

	assign int_clear = (commit && avs_write && sel_stat) ?
	                   (avs_writedata[`CFDMC_IRQ_W-1:0] & be_mask[`CFDMC_IRQ_W-1:0]) :
	                   {`CFDMC_IRQ_W{1'b0}};

	genvar gi;
	generate
		for (gi = 0; gi < `CFDMC_IRQ_W; gi = gi + 1) begin : g_int
			// a new event beats a simultaneous write-one-to-clear
			always @(posedge core_clk or posedge rst) begin
				if (rst) begin
					int_stat_q[gi] <= 1'b0;
				end else if (int_events[gi]) begin
					int_stat_q[gi] <= 1'b1;
				end else if (int_clear[gi]) begin
					int_stat_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			int_mask_q <= {`CFDMC_IRQ_W{1'b0}};
		end else if (commit && avs_write && sel_mask) begin
			int_mask_q <= (avs_writedata[`CFDMC_IRQ_W-1:0] & be_mask[`CFDMC_IRQ_W-1:0]) |
			              (int_mask_q & ~be_mask[`CFDMC_IRQ_W-1:0]);
		end
	end

	// level output: stays high until the bit is cleared or masked
	assign irq = |(int_stat_q & int_mask_q);

	// transmit-side bit controls are registered so they change only on a clock edge
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			esi_tx <= 1'b0;
			brs_tx <= 1'b0;
		end else begin
			esi_tx <= gw_q ? (msg_esi | error_passive) : error_passive;
			brs_tx <= msg_brs & ~rate_dis_q;
		end
	end

	// with the restriction off the attempt setting is masked, not passed through
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			retry_limit_active <= 1'b0;
			retry_attempt_used <= 2'h0;
		end else begin
			retry_limit_active <= retry_q;
			retry_attempt_used <= retry_q ? retry_attempt_setting : 2'h0;
		end
	end

	// the bypass path trades glitch immunity for a faster wake-up
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_detect <= 1'b0;
		end else begin
			wake_detect <= waken_q ? wake_filtered : wake_raw;
		end
	end

	// exactly one of the two outcomes pulses for each exception
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			form_error    <= 1'b0;
			bus_integrate <= 1'b0;
		end else begin
			form_error    <= proto_exception & pxd_q;
			bus_integrate <= proto_exception & ~pxd_q;
		end
	end

	assign mode_status            = cur_q;
	assign abort_all_pending      = abort_q;
	assign transmit_queue_enable  = queue_en_q;
	assign transmit_queue_reserve = queue_en_q;
	assign store_sent_events      = evt_store_q;
	assign sent_event_reserve     = evt_store_q;
	assign system_error_target    = serr_q;
	assign wake_filter_time       = wake_time_q;
	assign crc_stuff_count_en     = crc_q;
	assign crc_init_nonzero       = crc_q;
	assign data_byte_filter_count = dbc_q;

	// gap timer counts arbitration bit times after each sent frame
	cfdmc_tx_gap #(
		.CNT_W (13)
	) u_gap (
		.core_clk   (core_clk),
		.rst        (rst),
		.gap_code   (gap_q),
		.bit_tick   (arb_bit_tick),
		.frame_done (tx_frame_done),
		.gap_clear  (tx_gap_clear)
	);

endmodule
`default_nettype wire

// ### logic/cfdmc_regs.vh
`ifndef CFDMC_REGS_VH
`define CFDMC_REGS_VH

`define CFDMC_OFS_CONTROL   8'h00
`define CFDMC_OFS_INT_STAT  8'h04
`define CFDMC_OFS_INT_MASK  8'h08

`define CFDMC_GAP_LSB       28
`define CFDMC_ABORT_BIT     27
`define CFDMC_REQ_LSB       24
`define CFDMC_STAT_LSB      21
`define CFDMC_QUEUE_EN_BIT  20
`define CFDMC_EVT_STORE_BIT 19
`define CFDMC_SERR_BIT      18
`define CFDMC_GW_BIT        17
`define CFDMC_RETRY_BIT     16
`define CFDMC_RATE_DIS_BIT  12
`define CFDMC_BUSY_BIT      11
`define CFDMC_WAKE_TIME_LSB 9
`define CFDMC_WAKEN_BIT     8
`define CFDMC_PXD_BIT       6
`define CFDMC_CRC_BIT       5
`define CFDMC_DBC_LSB       0

`define CFDMC_MODE_NORMAL   3'h0
`define CFDMC_MODE_SLEEP    3'h1
`define CFDMC_MODE_INT_LB   3'h2
`define CFDMC_MODE_LISTEN   3'h3
`define CFDMC_MODE_CONFIG   3'h4
`define CFDMC_MODE_EXT_LB   3'h5
`define CFDMC_MODE_CLASSIC  3'h6
`define CFDMC_MODE_RESTRICT 3'h7

`define CFDMC_RST_GAP       4'h0
`define CFDMC_RST_QUEUE_EN  1'b1
`define CFDMC_RST_EVT_STORE 1'b1
`define CFDMC_RST_WAKE_TIME 2'h3
`define CFDMC_RST_WAKEN     1'b1
`define CFDMC_RST_PXD       1'b1
`define CFDMC_RST_CRC       1'b1
`define CFDMC_RST_DBC       5'h00

`define CFDMC_IRQ_MODE      0
`define CFDMC_IRQ_ABORT     1
`define CFDMC_IRQ_SERR      2
`define CFDMC_IRQ_PXE       3
`define CFDMC_IRQ_W         4

`define CFDMC_GAP_MAX_CODE  4'hc
`define CFDMC_GAP_MAX_BITS  13'h1000

`endif

// ### logic/cfdmc_tx_gap.v
`timescale 1ns/1ps
`default_nettype none
`include "cfdmc_regs.vh"

module cfdmc_tx_gap #(
	parameter CNT_W = 13
) (
	input  wire             core_clk,
	input  wire             rst,
	input  wire [3:0]       gap_code,
	input  wire             bit_tick,
	input  wire             frame_done,
	output reg              gap_clear
);

	reg  [CNT_W-1:0] count_q;
	reg  [CNT_W-1:0] count_d;
	reg  [CNT_W-1:0] load_val;

	// doubling codes; every code at or above the top one saturates
	always @* begin
		if (gap_code == 4'h0) begin
			load_val = {CNT_W{1'b0}};
		end else if (gap_code >= `CFDMC_GAP_MAX_CODE) begin
			load_val = `CFDMC_GAP_MAX_BITS;
		end else begin
			load_val = {{(CNT_W-1){1'b0}}, 1'b1} << gap_code;
		end
	end

	always @* begin
		count_d = count_q;
		if (frame_done) begin
			count_d = load_val;
		end else if (bit_tick && count_q != {CNT_W{1'b0}}) begin
			count_d = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_q   <= {CNT_W{1'b0}};
			gap_clear <= 1'b1;
		end else begin
			count_q   <= count_d;
			gap_clear <= (count_d == {CNT_W{1'b0}});
		end
	end

endmodule
`default_nettype wire
